// ===== hdl/pis_pkg.sv
// shared types and constants for the parallel issue scheduler
package pis_pkg;

    // ----------
    // sizes
    // ----------
    localparam int PIS_WIN = 4;
    localparam int PIS_XLEN = 32;
    localparam int PIS_NREG = 32;
    localparam int PIS_RF_PORTS = 6;
    localparam logic [2:0] PIS_WIN_SLOTS = 3'h4;

    // ----------
    // instruction word field positions
    // ----------
    localparam int PIS_OP_LSB = 24;
    localparam int PIS_DST_LSB = 19;
    localparam int PIS_S1_LSB = 14;
    localparam int PIS_S2_LSB = 9;
    localparam int PIS_TGT_LSB = 0;

    // ----------
    // reset values and address steps
    // ----------
    localparam logic [31:0] PIS_RESET_IP = 32'h0000_0000;
    localparam logic [31:0] PIS_LINE_BYTES = 32'h0000_0010;
    localparam logic [31:0] PIS_NO_PREFETCH = 32'hFFFF_FFFF;

    // ----------
    // micro-flow rom: two simple opcodes for each complex opcode [1:0]
    // ----------
    localparam logic [0:7][7:0] PIS_UF_ROM = {
        8'h40, 8'h44, 8'h70, 8'h41,
        8'h80, 8'h42, 8'hA0, 8'h90
    };

    typedef enum logic [1:0] {
        PIS_SIDE_CTRL, PIS_SIDE_REG, PIS_SIDE_MEM, PIS_SIDE_CPLX
    } pis_side_t;

    typedef enum logic [2:0] {
        PIS_U_NONE, PIS_U_EXE, PIS_U_MUL, PIS_U_BUS, PIS_U_DRAM, PIS_U_ADR
    } pis_unit_t;

    typedef struct packed {
        pis_side_t side;
        pis_unit_t unit;
        logic wr;
        logic [4:0] dst;
        logic [4:0] src1;
        logic [4:0] src2;
    } pis_dec_t;

    typedef struct packed {
        logic valid;
        pis_unit_t unit;
        logic [31:0] word;
    } pis_issue_t;

    typedef struct packed {
        logic exe;
        logic mul;
        logic bus_full;
        logic dram;
        logic adr;
    } pis_busy_t;

    // side and unit come from the opcode byte: [7:6] side, [5:4] unit
    function automatic pis_dec_t pis_decode(input logic [31:0] w);
        pis_dec_t d;
        logic [7:0] op;
        op = w[PIS_OP_LSB +: 8];
        d.dst = w[PIS_DST_LSB +: 5];
        d.src1 = w[PIS_S1_LSB +: 5];
        d.src2 = w[PIS_S2_LSB +: 5];
        d.side = pis_side_t'(op[7:6]);
        d.unit = PIS_U_NONE;
        d.wr = 1'b0;
        if (d.side == PIS_SIDE_REG) begin
            d.unit = (op[5:4] == 2'h3) ? PIS_U_MUL : PIS_U_EXE;
            d.wr = 1'b1;
        end else if (d.side == PIS_SIDE_MEM) begin
            case (op[5:4])
                2'h0: d.unit = PIS_U_BUS;
                2'h1: d.unit = PIS_U_DRAM;
                default: d.unit = PIS_U_ADR;
            endcase
            // bus and data ram stores (op[3] set) carry data in src2 and write nothing; address unit words always write
            d.wr = (d.unit == PIS_U_ADR) || !op[3];
        end
        return d;
    endfunction

endpackage

// ===== hdl/pis_regfile.sv
// six-ported register file shared by the parallel processing units
`timescale 1ns/1ps
module pis_regfile
    import pis_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // one write and one read port per processing unit
    input wire logic [PIS_RF_PORTS-1:0] we,
    input wire logic [PIS_RF_PORTS-1:0][4:0] waddr,
    input wire logic [PIS_RF_PORTS-1:0][31:0] wdata,
    input wire logic [PIS_RF_PORTS-1:0][4:0] raddr,
    output logic [PIS_RF_PORTS-1:0][31:0] rdata
);

    logic [PIS_NREG-1:0][31:0] regs;

    // writes: when two ports hit one register, the higher-numbered port wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            regs <= '0;
        end else begin
            for (int p = 0; p < PIS_RF_PORTS; p++) begin // [RL17]
                if (we[p]) begin
                    regs[waddr[p]] <= wdata[p];
                end
            end
        end
    end

    // reads: every port independent in the same clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata <= '0;
        end else begin
            for (int p = 0; p < PIS_RF_PORTS; p++) begin // [RL17]
                rdata[p] <= regs[raddr[p]];
            end
        end
    end

endmodule // pis_regfile

// ===== hdl/pis_sched.sv
// instruction scheduler: four-word window, side decode and group issue
`timescale 1ns/1ps
// Function
// RL1 - at most three instructions issued per clock; sustains two on average
// RL2 - every clock examine four unexecuted words and issue all issuable ones
// RL3 - decode compute, storage or control side for each window word
// RL4 - groups limited to compute+storage pair, each optionally with later control
// RL5 - units take a group at once; window then moves to next words
// RL6 - withhold group when two instructions write the same register
// RL7 - withhold group when a later instruction reads an earlier one's result
// RL8 - shared sources and read-before-write pairs may issue together
// RL9 - parallel issue gives the same results as sequential order
// RL10 - delay an instruction on a locked register or busy unit
// RL11 - cache supplies three or four words per clock
// RL12 - predict next-clock cache miss every clock and fetch early
// RL13 - storage work goes to bus, data ram or address units
// RL14 - multiply family to multiply-divide unit, the rest to execution unit
// RL15 - control instructions change the next fetch pointer directly
// RL16 - complex instructions replaced by their rom micro-flow
// RL17 - six register file ports, one per processing unit
// RL18 - a locked-register stall is retried every clock
// RL19 - unissued words stay in order at the window head
module pis_sched
    import pis_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // instruction cache delivery
    input wire logic cache_valid,
    input wire logic [2:0] cache_count,
    input wire logic [PIS_WIN-1:0][31:0] cache_words,
    output logic [2:0] take_count,
    output logic [31:0] fetch_ip,
    // fetch look-ahead
    output logic [31:0] lookahead_addr,
    input wire logic lookahead_hit,
    output logic prefetch_req,
    output logic [31:0] prefetch_addr,
    // scoreboard and unit availability
    input wire logic [PIS_NREG-1:0] reg_locked,
    input wire pis_busy_t unit_busy,
    // dispatch to the two machine buses
    output pis_issue_t reg_issue,
    output pis_issue_t mem_issue,
    output logic branch_taken,
    // register file ports of the six units
    input wire logic [PIS_RF_PORTS-1:0] rf_we,
    input wire logic [PIS_RF_PORTS-1:0][4:0] rf_waddr,
    input wire logic [PIS_RF_PORTS-1:0][31:0] rf_wdata,
    input wire logic [PIS_RF_PORTS-1:0][4:0] rf_raddr,
    output logic [PIS_RF_PORTS-1:0][31:0] rf_rdata
);

    // ----------
    // state
    // ----------
    typedef enum logic {PIS_ST_RUN, PIS_ST_FLOW} pis_state_t;

    pis_state_t state, next_state;
    logic flow_step, next_flow_step;
    logic [PIS_WIN-1:0][31:0] win;
    logic [2:0] win_cnt;
    logic [PIS_WIN-1:0][31:0] next_win;
    logic [2:0] next_win_cnt;
    pis_issue_t next_reg_issue, next_mem_issue;
    logic redirect;
    logic [31:0] target;

    // ----------
    // helpers
    // ----------
    function automatic logic unit_free(input pis_unit_t u,
                                       input pis_busy_t b);
        case (u)
            PIS_U_EXE: return !b.exe;
            PIS_U_MUL: return !b.mul;
            PIS_U_BUS: return !b.bus_full;
            PIS_U_DRAM: return !b.dram;
            PIS_U_ADR: return !b.adr;
            default: return 1'b1;
        endcase
    endfunction

    // source busy, or destination busy for a writer
    function automatic logic regs_locked(input pis_dec_t d,
                                         input logic [PIS_NREG-1:0] l);
        return l[d.src1] || l[d.src2] || (d.wr && l[d.dst]);
    endfunction

    // pair hazard: same destination, or earlier result read later
    function automatic logic pair_hazard(input pis_dec_t a,
                                         input pis_dec_t b);
        logic waw, raw;
        waw = a.wr && b.wr && (a.dst == b.dst);
        raw = a.wr && ((a.dst == b.src1) || (a.dst == b.src2));
        return waw || raw;
    endfunction

    // micro-flow word: rom opcode with the complex word's operands
    function automatic logic [31:0] flow_word(input logic [31:0] w,
                                              input logic step);
        logic [2:0] idx;
        idx = {w[PIS_OP_LSB +: 2], step};
        return {PIS_UF_ROM[idx], w[PIS_OP_LSB-1:0]};
    endfunction

    // ----------
    // issue selection and window compaction
    // ----------
    always_comb begin
        pis_dec_t dec [PIS_WIN];
        logic [PIS_WIN-1:0] val, rm;
        logic r_sel, m_sel, r_go, m_go, c_go, c_found, r_ok, m_ok;
        logic [1:0] r_pos, m_pos, c_pos, c_from;
        logic [2:0] k, free;
        pis_dec_t fd;
        logic [31:0] fw;
        dec = '{default: '0};
        val = '0;
        rm = '0;
        r_sel = 1'b0;
        m_sel = 1'b0;
        r_go = 1'b0;
        m_go = 1'b0;
        c_go = 1'b0;
        c_found = 1'b0;
        r_ok = 1'b0;
        m_ok = 1'b0;
        r_pos = 2'h0;
        m_pos = 2'h0;
        c_pos = 2'h0;
        c_from = 2'h1;
        k = 3'h0;
        free = 3'h0;
        fw = '0;
        fd = '0;
        next_state = state;
        next_flow_step = flow_step;
        next_reg_issue = '0;
        next_mem_issue = '0;
        redirect = 1'b0;
        target = '0;
        next_win = '0;
        next_win_cnt = 3'h0;
        take_count = 3'h0;
        for (int i = 0; i < PIS_WIN; i++) begin
            dec[i] = pis_decode(win[i]); // [RL3]
            val[i] = (3'(i) < win_cnt);
        end
        if (state == PIS_ST_FLOW) begin
            // rom words issue one per clock in place of the complex word
            fw = flow_word(win[0], flow_step); // [RL16]
            fd = pis_decode(fw);
            if (!regs_locked(fd, reg_locked) &&
                unit_free(fd.unit, unit_busy)) begin // [RL10] [RL18]
                if (fd.side == PIS_SIDE_REG) begin
                    next_reg_issue = '{1'b1, fd.unit, fw};
                end else begin
                    next_mem_issue = '{1'b1, fd.unit, fw};
                end
                next_flow_step = 1'b1;
                if (flow_step) begin
                    rm[0] = 1'b1;
                    next_state = PIS_ST_RUN;
                    next_flow_step = 1'b0;
                end
            end
        end else if (val[0]) begin
            // candidate group from the head word's side
            unique case (dec[0].side) // [RL4]
                PIS_SIDE_REG: begin
                    r_sel = 1'b1;
                    r_pos = 2'h0;
                    // pair only with an immediately following storage word
                    if (val[1] && dec[1].side == PIS_SIDE_MEM &&
                        !pair_hazard(dec[0], dec[1])) begin // [RL6] [RL7] [RL8]
                        m_sel = 1'b1;
                        m_pos = 2'h1;
                        c_from = 2'h2;
                    end
                end
                PIS_SIDE_MEM: begin
                    m_sel = 1'b1;
                    m_pos = 2'h0;
                end
                PIS_SIDE_CTRL: begin
                    c_found = 1'b1;
                    c_pos = 2'h0;
                end
                PIS_SIDE_CPLX: begin
                    next_state = PIS_ST_FLOW; // [RL16]
                    next_flow_step = 1'b0;
                end
            endcase
            // a control word anywhere later in the window may join
            if (r_sel || m_sel) begin
                for (int i = 1; i < PIS_WIN; i++) begin
                    if (!c_found && 2'(i) >= c_from && val[i] &&
                        dec[i].side == PIS_SIDE_CTRL) begin // [RL4]
                        c_found = 1'b1;
                        c_pos = 2'(i);
                    end
                end
            end
            // in order: a stalled word stops every word behind it
            r_ok = !regs_locked(dec[r_pos], reg_locked) &&
                   unit_free(dec[r_pos].unit, unit_busy); // [RL10] [RL18]
            m_ok = !regs_locked(dec[m_pos], reg_locked) &&
                   unit_free(dec[m_pos].unit, unit_busy); // [RL10]
            r_go = r_sel && r_ok;
            m_go = m_sel && m_ok && (!r_sel || r_go); // [RL9]
            c_go = c_found && (!r_sel || r_go) && (!m_sel || m_go); // [RL9]
            // at most one per side: three per clock at most
            if (r_go) begin // [RL1] [RL14]
                next_reg_issue = '{1'b1, dec[r_pos].unit, win[r_pos]};
                rm[r_pos] = 1'b1;
            end
            if (m_go) begin // [RL13]
                next_mem_issue = '{1'b1, dec[m_pos].unit, win[m_pos]};
                rm[m_pos] = 1'b1;
            end
            if (c_go) begin // [RL15]
                rm[c_pos] = 1'b1;
                redirect = 1'b1;
                target = {6'h00, win[c_pos][PIS_TGT_LSB +: 24], 2'h0};
            end
        end
        // survivors keep their order at the head; words past a taken
        // branch belong to the old path and are dropped
        for (int i = 0; i < PIS_WIN; i++) begin
            if (val[i] && !rm[i] && !(redirect && 2'(i) > c_pos)) begin
                next_win[k[1:0]] = win[i]; // [RL19] [RL5]
                k = k + 3'h1;
            end
        end
        // refill from the cache unless the fetch path is being redirected
        free = PIS_WIN_SLOTS - k;
        if (cache_valid && !redirect) begin // [RL11]
            take_count = (cache_count < free) ? cache_count : free;
        end
        for (int j = 0; j < PIS_WIN; j++) begin
            if (3'(j) < take_count) begin
                next_win[k[1:0]] = cache_words[j]; // [RL5] [RL2]
                k = k + 3'h1;
            end
        end
        next_win_cnt = k;
    end

    // ----------
    // window, mode and dispatch registers
    // ----------
    // window holds up to four unexecuted words; no refill in a redirecting clock
    always_ff @(posedge mclk) begin
        if (srst) begin
            win <= '0;
            win_cnt <= 3'h0;
        end else begin
            win <= next_win; // [RL2]
            win_cnt <= next_win_cnt;
        end
    end

    // micro-flow sequencing
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= PIS_ST_RUN;
            flow_step <= 1'b0;
        end else begin
            state <= next_state;
            flow_step <= next_flow_step;
        end
    end

    // dispatch: units acknowledge at once, so a pulse is a taken issue
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_issue <= '0;
            mem_issue <= '0;
            branch_taken <= 1'b0;
        end else begin
            reg_issue <= next_reg_issue; // [RL5]
            mem_issue <= next_mem_issue;
            branch_taken <= redirect;
        end
    end

    // ----------
    // fetch pointer and miss look-ahead
    // ----------
    // control words are executed here by steering the fetch pointer
    always_ff @(posedge mclk) begin
        if (srst) begin
            fetch_ip <= PIS_RESET_IP;
        end else if (redirect) begin
            fetch_ip <= target; // [RL15]
        end else begin
            fetch_ip <= fetch_ip + {27'h0, take_count, 2'h0};
        end
    end

    // next line is probed each clock; a predicted miss is fetched once
    assign lookahead_addr = fetch_ip + PIS_LINE_BYTES; // [RL12]

    // remembering the last request avoids repeating the same fetch
    always_ff @(posedge mclk) begin
        if (srst) begin
            prefetch_req <= 1'b0;
            prefetch_addr <= PIS_NO_PREFETCH;
        end else begin
            prefetch_req <= !lookahead_hit &&
                            (lookahead_addr != prefetch_addr); // [RL12]
            if (!lookahead_hit) begin
                prefetch_addr <= lookahead_addr;
            end
        end
    end

    // ----------
    // register file
    // ----------
    pis_regfile u_regfile (
        .mclk(mclk),
        .srst(srst),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata),
        .raddr(rf_raddr),
        .rdata(rf_rdata)
    );

endmodule // pis_sched

// ===== testbench/pis_cache_model.sv
// instruction cache model feeding the scheduler's window
`timescale 1ns/1ps
module pis_cache_model
    import pis_pkg::*;
(
    // bench control
    input wire logic en,
    // scheduler side
    input wire logic [31:0] fetch_ip,
    input wire logic [31:0] lookahead_addr,
    output logic cache_valid,
    output logic [2:0] cache_count,
    output logic [PIS_WIN-1:0][31:0] cache_words,
    output logic lookahead_hit
);
    logic [31:0] mem [0:63];
    // three words at odd word addresses, four otherwise
    always_comb begin
        cache_valid = en;
        cache_count = fetch_ip[2] ? 3'h3 : 3'h4;
        for (int j = 0; j < PIS_WIN; j++) begin
            cache_words[j] = mem[fetch_ip[7:2] + 6'(j)];
        end
        // an unoffered slot carries junk so it can never pass as code
        if (fetch_ip[2]) begin
            cache_words[3] = ~cache_words[3];
        end
        // lines with address bit 6 set are resident, others miss
        lookahead_hit = lookahead_addr[6];
    end
endmodule // pis_cache_model

// ===== testbench/pis_sched_checker.sv
// concurrent checks on the parallel issue scheduler's ports
`timescale 1ns/1ps
module pis_sched_checker
    import pis_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // instruction cache and look-ahead
    input wire logic cache_valid,
    input wire logic [2:0] cache_count,
    input wire logic [2:0] take_count,
    input wire logic [31:0] fetch_ip,
    input wire logic [31:0] lookahead_addr,
    input wire logic lookahead_hit,
    input wire logic prefetch_req,
    input wire logic [31:0] prefetch_addr,
    // scoreboard and dispatch
    input wire logic [PIS_NREG-1:0] reg_locked,
    input wire pis_busy_t unit_busy,
    input wire pis_issue_t reg_issue,
    input wire pis_issue_t mem_issue,
    input wire logic branch_taken
);
    // ----------
    // operand masks of the issued words
    // ----------
    logic mwr;
    logic [31:0] rneed, mneed, need;
    // stores outside the address unit write nothing, so only their sources count against a writer
    always_comb begin
        mwr = mem_issue.word[29] || !mem_issue.word[27];
        rneed = (32'h1 << reg_issue.word[23:19])
            | (32'h1 << reg_issue.word[18:14])
            | (32'h1 << reg_issue.word[13:9]);
        mneed = ({31'h0, mwr} << mem_issue.word[23:19])
            | (32'h1 << mem_issue.word[18:14])
            | (32'h1 << mem_issue.word[13:9]);
        need = (reg_issue.valid ? rneed : 32'h0)
            | (mem_issue.valid ? mneed : 32'h0);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // ----------
    // properties
    // ----------
    property p_look; lookahead_addr == fetch_ip + 32'h10; endproperty
    a_look: assert property (p_look) else $error("lookahead");
    property p_pf; !lookahead_hit && lookahead_addr != prefetch_addr
        |=> prefetch_req && prefetch_addr == $past(lookahead_addr); endproperty
    a_pf: assert property (p_pf) else $error("prefetch");
    property p_take; take_count <= (cache_valid ? cache_count : 3'h0);
    endproperty
    a_take: assert property (p_take) else $error("take count");
    property p_fetch; take_count != 3'h0 |=>
        fetch_ip == $past(fetch_ip) + {27'h0, $past(take_count), 2'h0};
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch step");
    property p_branch; branch_taken |-> $past(take_count) == 3'h0; endproperty
    a_branch: assert property (p_branch) else $error("branch take");
    property p_reg_unit; reg_issue.valid |-> reg_issue.word[31:30] == 2'h1
        && reg_issue.unit == (reg_issue.word[29:28] == 2'h3 ? PIS_U_MUL
        : PIS_U_EXE); endproperty
    a_reg_unit: assert property (p_reg_unit) else $error("reg unit");
    property p_mem_unit; mem_issue.valid |-> mem_issue.word[31:30] == 2'h2
        && mem_issue.unit == (mem_issue.word[29] ? PIS_U_ADR
        : mem_issue.word[28] ? PIS_U_DRAM : PIS_U_BUS); endproperty
    a_mem_unit: assert property (p_mem_unit) else $error("mem unit");
    property p_lock; ($past(reg_locked) & need) == 32'h0; endproperty
    a_lock: assert property (p_lock) else $error("locked issue");
    property p_busy; reg_issue.valid && reg_issue.unit == PIS_U_MUL
        |-> !$past(unit_busy.mul); endproperty
    a_busy: assert property (p_busy) else $error("busy issue");
    property p_dep; reg_issue.valid && mem_issue.valid
        |-> ((32'h1 << reg_issue.word[23:19]) & mneed) == 32'h0; endproperty
    a_dep: assert property (p_dep) else $error("dependent pair");
endmodule // pis_sched_checker

bind pis_sched pis_sched_checker pis_sched_checker_i (.mclk, .srst,
    .cache_valid, .cache_count, .take_count, .fetch_ip,
    .lookahead_addr, .lookahead_hit, .prefetch_req, .prefetch_addr,
    .reg_locked, .unit_busy, .reg_issue, .mem_issue, .branch_taken);

// ===== testbench/pis_sched_test.sv
// self-checking bench for the parallel issue scheduler
`timescale 1ns/1ps
module pis_sched_test
    import pis_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b0;
    logic cache_valid, lookahead_hit, prefetch_req, branch_taken;
    logic [2:0] cache_count, take_count;
    logic [PIS_WIN-1:0][31:0] cache_words;
    logic [31:0] fetch_ip, lookahead_addr, prefetch_addr;
    logic [PIS_NREG-1:0] reg_locked = '0;
    pis_busy_t unit_busy = '0;
    pis_issue_t reg_issue, mem_issue;
    logic [PIS_RF_PORTS-1:0] rf_we = '0;
    logic [PIS_RF_PORTS-1:0][4:0] rf_waddr = '0, rf_raddr = '0;
    logic [PIS_RF_PORTS-1:0][31:0] rf_wdata = '0, rf_rdata;
    int mismatches = 0;
    int checks = 0;

    initial begin
        forever #25 mclk = ~mclk;
    end

    pis_sched pis_sched_i (.mclk, .srst, .cache_valid, .cache_count,
        .cache_words, .take_count, .fetch_ip, .lookahead_addr,
        .lookahead_hit, .prefetch_req, .prefetch_addr, .reg_locked,
        .unit_busy, .reg_issue, .mem_issue, .branch_taken, .rf_we,
        .rf_waddr, .rf_wdata, .rf_raddr, .rf_rdata);
    pis_cache_model pis_cache_model_i (.en, .fetch_ip, .lookahead_addr,
        .cache_valid, .cache_count, .cache_words, .lookahead_hit);

    // ----------
    // helpers
    // ----------
    function automatic logic [31:0] iw(logic [7:0] op, logic [4:0] d,
        logic [4:0] a, logic [4:0] b);
        return {op, d, a, b, 9'h0};
    endfunction

    task automatic chk(string n, logic [39:0] s, logic [39:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // sample just after an edge so registered outputs have landed
    task automatic edge_settle();
        @(posedge mclk);
        #1;
    endtask

    // reset and refill the program with independent compute words
    task automatic restart();
        @(posedge mclk);
        srst <= 1'b1;
        en <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            pis_cache_model_i.mem[i] = iw(8'h40, 5'h1F, 5'h1E, 5'h1E);
        end
        @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
    endtask

    // offer from the release edge; first issue shows two edges later
    task automatic go();
        en <= 1'b1;
        @(posedge mclk);
        edge_settle();
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        #1;
        chk("ip", fetch_ip, PIS_RESET_IP);
        chk("quiet", {reg_issue.valid, mem_issue.valid, branch_taken}, 0);
        chk("pf_addr", prefetch_addr, PIS_NO_PREFETCH);
        chk("rf", rf_rdata[5], 0);
        @(posedge mclk);
        srst <= 1'b0;
        edge_settle();
        chk("pf", {prefetch_req, prefetch_addr}, {1'b1, 32'h10});
        edge_settle();
        chk("pf_once", prefetch_req, 0);
    endtask

    // full three-wide group: compute, storage, later control
    task automatic t_group();
        logic [31:0] p [4];
        p = '{iw(8'h40, 5'h2, 5'h0, 5'h1), iw(8'h80, 5'h5, 5'h3, 5'h4),
            iw(8'h40, 5'h6, 5'h7, 5'h8), 32'h0000_0010};
        restart();
        for (int i = 0; i < 4; i++) begin
            pis_cache_model_i.mem[i] = p[i];
        end
        en <= 1'b1;
        #1;
        chk("take", take_count, 4);
        edge_settle();
        chk("ip", fetch_ip, 32'h10);
        edge_settle();
        chk("reg", reg_issue, {1'b1, PIS_U_EXE, p[0]});
        chk("mem", mem_issue, {1'b1, PIS_U_BUS, p[1]});
        chk("br", {branch_taken, fetch_ip}, {1'b1, 32'h40});
        edge_settle();
        chk("skipped", reg_issue, {1'b1, PIS_U_EXE, p[2]});
    endtask

    // storage word behind a compute word writing r2
    task automatic t_dep();
        logic [31:0] m [4];
        logic [3:0] par;
        m = '{iw(8'h88, 5'h0, 5'h3, 5'h2), iw(8'h80, 5'h2, 5'h3, 5'h4),
            iw(8'h80, 5'h0, 5'h3, 5'h4), iw(8'h88, 5'h0, 5'h3, 5'h0)};
        par = 4'hC;
        for (int i = 0; i < 4; i++) begin
            restart();
            pis_cache_model_i.mem[0] = iw(8'h40, 5'h2, 5'h0, 5'h1);
            pis_cache_model_i.mem[1] = m[i];
            go();
            chk("pair", mem_issue.valid, par[i]);
            edge_settle();
            chk("after", mem_issue.valid, !par[i]);
        end
    endtask

    task automatic t_units();
        logic [7:0] op [5];
        pis_unit_t u [5];
        op = '{8'h40, 8'h70, 8'h80, 8'h90, 8'hA0};
        u = '{PIS_U_EXE, PIS_U_MUL, PIS_U_BUS, PIS_U_DRAM, PIS_U_ADR};
        for (int i = 0; i < 5; i++) begin
            restart();
            pis_cache_model_i.mem[0] = iw(op[i], 5'h3, 5'h4, 5'h5);
            go();
            chk("unit", i < 2 ? reg_issue : mem_issue,
                {1'b1, u[i], iw(op[i], 5'h3, 5'h4, 5'h5)});
        end
    endtask

    // a blocked head word holds everything behind it until freed
    task automatic t_stall(logic [31:0] lk, pis_busy_t bz, logic [7:0] op);
        restart();
        reg_locked <= lk;
        unit_busy <= bz;
        pis_cache_model_i.mem[0] = iw(op, 5'h2, 5'h7, 5'h1);
        pis_cache_model_i.mem[1] = iw(8'h80, 5'h5, 5'h3, 5'h4);
        go();
        chk("stall", {reg_issue.valid, mem_issue.valid}, 0);
        @(posedge mclk);
        reg_locked <= '0;
        unit_busy <= '0;
        #1;
        chk("held", {reg_issue.valid, mem_issue.valid}, 0);
        edge_settle();
        chk("retry", {reg_issue.valid, mem_issue.valid},
            op[7] ? 2'h1 : 2'h3);
    endtask

    // complex word replaced by its two rom words, one per clock
    task automatic t_cplx();
        logic [31:0] w;
        w = iw(8'hC1, 5'h9, 5'hA, 5'hB);
        restart();
        pis_cache_model_i.mem[0] = w;
        go();
        // one clock to enter flow mode before the first rom word
        edge_settle();
        chk("flow0", reg_issue, {1'b1, PIS_U_MUL, PIS_UF_ROM[2], w[23:0]});
        edge_settle();
        chk("flow1", reg_issue, {1'b1, PIS_U_EXE, PIS_UF_ROM[3], w[23:0]});
    endtask

    // two ports write one register; a read in that clock sees the old value
    task automatic t_rf();
        @(posedge mclk);
        rf_we <= 6'h11;
        rf_waddr[0] <= 5'h5;
        rf_waddr[4] <= 5'h5;
        rf_wdata[0] <= 32'hA5A5_A5A5;
        rf_wdata[4] <= 32'h1234_5678;
        rf_raddr[3] <= 5'h5;
        @(posedge mclk);
        rf_we <= '0;
        #1;
        chk("rf_old", rf_rdata[3], 0);
        edge_settle();
        chk("rf_new", rf_rdata[3], 32'h1234_5678);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        t_reset();
        t_group();
        t_dep();
        t_units();
        t_stall(32'h80, pis_busy_t'(5'h00), 8'h40);
        t_stall(32'h0, pis_busy_t'(5'h08), 8'h70);
        t_stall(32'h0, pis_busy_t'(5'h02), 8'h90);
        t_cplx();
        t_rf();
        print_verdict();
    end

    // hang guard far past the point where the bench finishes
    initial begin
        #2000000;
        mismatches++;
        print_verdict();
    end
endmodule // pis_sched_test
